/* File: include/fhri_pkg.sv */
package fhri_pkg;
  localparam logic [9:0] FHRI_ADDR_RATE = 10'h3F4;
  localparam logic [9:0] FHRI_ADDR_STATUS = 10'h3F4;
  localparam logic [9:0] FHRI_ADDR_FIFO = 10'h3F5;
  localparam logic [9:0] FHRI_ADDR_INPUT = 10'h3F7;
  localparam logic [7:0] FHRI_RATE_RESET = 8'h02;
  localparam int FHRI_RATE_LSB = 0;
  localparam int FHRI_PRECOMP_LSB = 2;
  localparam int FHRI_PWRDN_BIT = 6;
  localparam int FHRI_SWRST_BIT = 7;
  localparam int FHRI_DIO_BIT = 6;
  localparam int FHRI_RQM_BIT = 7;
  localparam int FHRI_NONDMA_BIT = 5;
  localparam int FHRI_BUSY_BIT = 4;
  localparam logic [2:0] FHRI_PRECOMP_OFF = 3'h7;
  localparam logic [2:0] FHRI_PRECOMP_DEF = 3'h0;
  localparam logic [1:0] FHRI_RATE_1M = 2'h3;
  localparam logic [1:0] FHRI_RATE_500 = 2'h0;
  localparam logic [1:0] FHRI_RATE_300 = 2'h1;
  localparam logic [1:0] FHRI_RATE_250 = 2'h2;
  localparam logic [1:0] FHRI_OPT_3MODE = 2'h1;
  localparam logic [1:0] FHRI_OPT_2MEG = 2'h2;
  // precomp delays in steps of 20.8 ns (one step at 2 Mbps)
  localparam logic [3:0] FHRI_STEP_2M_DEF = 4'h1;
  localparam logic [3:0] FHRI_STEP_1M_DEF = 4'h2;
  localparam logic [3:0] FHRI_STEP_LOW_DEF = 4'h6;
  localparam int FHRI_FIFO_DEPTH = 16;
  localparam logic [7:0] FHRI_FILL_BYTE = 8'h00;
  typedef enum logic [2:0] {
    FHRI_RATE_CODE_250K, FHRI_RATE_CODE_300K, FHRI_RATE_CODE_500K,
    FHRI_RATE_CODE_1M, FHRI_RATE_CODE_2M
  } fhri_rate_t;
endpackage

/* File: include/fhri_bus_if.sv */
`timescale 1ns/100ps
interface fhri_bus_if;
  logic [9:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rdata_oe;
  modport device(input addr, input rd, input wr, input wdata, output rdata, output rdata_oe);
  modport host(output addr, output rd, output wr, output wdata, input rdata, input rdata_oe);
endinterface

/* File: src/fhri_device.sv */
`timescale 1ns/100ps
module fhri_device
  import fhri_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  fhri_bus_if.device bus,
  input wire logic [1:0] drive_rate_option_i,
  input wire logic density_polarity_i,
  input wire logic disk_change_n_i,
  input wire logic [1:0] config_rate_i,
  input wire logic config_rate_we_i,
  input wire logic output_reset_i,
  input wire logic [3:0] drive_seek_active_i,
  input wire logic cmd_busy_i,
  input wire logic non_dma_exec_i,
  input wire logic dev_to_host_i,
  input wire logic exec_start_i,
  input wire logic fifo_enable_i,
  input wire logic [7:0] precomp_track_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_wvalid_i,
  output logic core_wready_o,
  output logic [7:0] core_rdata_o,
  output logic core_rvalid_o,
  input wire logic core_rready_i,
  input wire logic transfer_error_i,
  input wire logic [7:0] current_track_i,
  output logic [1:0] rate_select_bits_o,
  output fhri_rate_t data_rate_o,
  output logic [3:0] precomp_steps_o,
  output logic density_output_o,
  output logic [1:0] rate_output_pin_o,
  output logic low_power_o,
  output logic soft_reset_o,
  output logic fifo_active_o,
  output logic fill_zero_o
);
  typedef struct packed {
    logic [7:0] rate_reg;
    logic [1:0] rate_now;
    logic density;
    logic low_power;
    logic soft_reset;
    logic fifo_on;
    logic fill_zero;
    logic [1:0][7:0] h2d_mem;
    logic [1:0] h2d_cnt;
    logic [1:0][7:0] d2h_mem;
    logic [1:0] d2h_cnt;
    logic [7:0] rdata;
    logic [7:0] rdata_oe;
    logic [2:0] dc_sync;
    logic dc_level;
  } fhri_dev_state_t;

  fhri_dev_state_t st, next_st;
  logic rate_wr, status_rd, fifo_wr, fifo_rd, input_rd;

  function automatic logic [3:0] fhri_precomp_steps(input logic [2:0] code,
                                                    input fhri_rate_t rate);
    logic [3:0] s;
    s = {1'b0, code};
    if (code == FHRI_PRECOMP_OFF) begin
      s = 4'h0;
    end else if (code == FHRI_PRECOMP_DEF) begin
      if (rate == FHRI_RATE_CODE_2M) begin
        s = FHRI_STEP_2M_DEF;
      end else if (rate == FHRI_RATE_CODE_1M) begin
        s = FHRI_STEP_1M_DEF;
      end else begin
        s = FHRI_STEP_LOW_DEF;
      end
    end else if (rate != FHRI_RATE_CODE_2M) begin
      s = {code, 1'b0};
    end
    return s;
  endfunction

  always_comb begin
    rate_wr = bus.wr && bus.addr == FHRI_ADDR_RATE;
    status_rd = bus.rd && bus.addr == FHRI_ADDR_STATUS;
    fifo_wr = bus.wr && bus.addr == FHRI_ADDR_FIFO;
    fifo_rd = bus.rd && bus.addr == FHRI_ADDR_FIFO;
    input_rd = bus.rd && bus.addr == FHRI_ADDR_INPUT;
  end

  always_comb begin
    next_st = st;
    next_st.soft_reset = 1'b0;
    next_st.rdata_oe = 8'h00;
    next_st.dc_sync = {st.dc_sync[1:0], disk_change_n_i};
    if (st.dc_sync[2] == st.dc_sync[1]) begin
      next_st.dc_level = st.dc_sync[2];
    end
    if (rate_wr) begin
      next_st.rate_reg = {1'b0, bus.wdata[6:0]};
      next_st.rate_now = bus.wdata[FHRI_RATE_LSB +: 2];
      next_st.low_power = bus.wdata[FHRI_PWRDN_BIT];
      next_st.soft_reset = bus.wdata[FHRI_SWRST_BIT];
    end else if (config_rate_we_i) begin
      next_st.rate_now = config_rate_i;
    end
    if (status_rd || fifo_rd || fifo_wr || st.soft_reset) begin
      next_st.low_power = 1'b0;
    end
    // density follows rate; only hardware reset forces it high
    next_st.density = (next_st.rate_now == FHRI_RATE_1M || next_st.rate_now == FHRI_RATE_500)
                      ~^ density_polarity_i;
    if (status_rd) begin
      next_st.rdata = {st.d2h_cnt != 2'h0 || (!dev_to_host_i && st.h2d_cnt != 2'h2),
                       dev_to_host_i, non_dma_exec_i, cmd_busy_i,
                       drive_seek_active_i};
      next_st.rdata_oe = 8'hFF;
    end else if (fifo_rd) begin
      next_st.rdata = st.d2h_mem[0];
      next_st.rdata_oe = 8'hFF;
    end else if (input_rd) begin
      next_st.rdata = {!st.dc_level, 7'h00};
      next_st.rdata_oe = 8'h80;
    end
    if (exec_start_i) begin
      next_st.fifo_on = fifo_enable_i;
      next_st.h2d_cnt = 2'h0;
      next_st.d2h_cnt = 2'h0;
    end else begin
      if (fifo_wr && st.h2d_cnt != 2'h2) begin
        next_st.h2d_mem[st.h2d_cnt[0]] = bus.wdata;
      end
      if (fifo_wr && st.h2d_cnt != 2'h2) begin
        next_st.h2d_cnt = st.h2d_cnt + 2'h1;
      end
      if (core_rvalid_o && core_rready_i) begin
        next_st.h2d_mem[0] = next_st.h2d_mem[1];
        next_st.h2d_cnt = next_st.h2d_cnt - 2'h1;
      end
      if (core_wvalid_i && core_wready_o) begin
        next_st.d2h_mem[st.d2h_cnt[0]] = core_wdata_i;
        next_st.d2h_cnt = st.d2h_cnt + 2'h1;
      end
      if (fifo_rd && st.d2h_cnt != 2'h0) begin
        next_st.d2h_mem[0] = next_st.d2h_mem[1];
        next_st.d2h_cnt = next_st.d2h_cnt - 2'h1;
      end
    end
    if (transfer_error_i) begin
      next_st.fill_zero = !dev_to_host_i;
    end else if (!cmd_busy_i) begin
      next_st.fill_zero = 1'b0;
    end
    if (!reset_n_i) begin
      next_st = '0;
      next_st.rate_reg = FHRI_RATE_RESET;
      next_st.rate_now = FHRI_RATE_RESET[1:0];
      next_st.density = 1'b1;
      next_st.dc_sync = 3'h7;
      next_st.dc_level = 1'b1;
    end else if (st.soft_reset || output_reset_i) begin
      next_st.fifo_on = 1'b0;
      next_st.h2d_cnt = 2'h0;
      next_st.d2h_cnt = 2'h0;
      next_st.fill_zero = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  always_comb begin
    // the far-side core moves bytes one way at a time; dev_to_host_i picks the write or the read port
    core_wready_o = dev_to_host_i && st.d2h_cnt != 2'h2;
    core_rvalid_o = !dev_to_host_i && st.h2d_cnt != 2'h0;
    core_rdata_o = st.fill_zero ? FHRI_FILL_BYTE : st.h2d_mem[0];
    case ({drive_rate_option_i, st.rate_now})
      {FHRI_OPT_3MODE, FHRI_RATE_300}: data_rate_o = FHRI_RATE_CODE_500K;
      {FHRI_OPT_2MEG, FHRI_RATE_300}: data_rate_o = FHRI_RATE_CODE_2M;
      default: begin
        case (st.rate_now)
          FHRI_RATE_1M: data_rate_o = FHRI_RATE_CODE_1M;
          FHRI_RATE_500: data_rate_o = FHRI_RATE_CODE_500K;
          FHRI_RATE_300: data_rate_o = FHRI_RATE_CODE_300K;
          default: data_rate_o = FHRI_RATE_CODE_250K;
        endcase
      end
    endcase
    precomp_steps_o = (current_track_i >= precomp_track_i) ?
        fhri_precomp_steps(st.rate_reg[FHRI_PRECOMP_LSB +: 3], data_rate_o) : 4'h0;
    rate_select_bits_o = st.rate_now;
    rate_output_pin_o = st.rate_now;
    density_output_o = st.density;
    low_power_o = st.low_power;
    soft_reset_o = st.soft_reset;
    fifo_active_o = st.fifo_on;
    fill_zero_o = st.fill_zero;
    bus.rdata = st.rdata;
    bus.rdata_oe = st.rdata_oe;
  end
endmodule

/* File: src/fhri_host.sv */
`timescale 1ns/100ps
module fhri_host
  import fhri_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  fhri_bus_if.host bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_kind_i,
  input wire logic [7:0] req_data_i,
  input wire logic req_dma_i,
  output logic req_ready_o,
  output logic [7:0] resp_data_o,
  output logic resp_valid_o
);
  typedef enum {
    FHRI_H_IDLE, FHRI_H_POLL, FHRI_H_WAIT, FHRI_H_XFER, FHRI_H_SETTLE, FHRI_H_GRAB
  } fhri_hstate_t;
  typedef struct packed {
    fhri_hstate_t fsm;
    logic [9:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic is_write;
    logic [7:0] resp;
    logic resp_valid;
  } fhri_host_state_t;

  fhri_host_state_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.rd = 1'b0;
    next_st.wr = 1'b0;
    next_st.resp_valid = 1'b0;
    case (st.fsm)
      FHRI_H_IDLE: begin
        if (req_valid_i) begin
          next_st.is_write = req_write_i;
          next_st.wdata = req_data_i;
          if (req_kind_i == 2'h1 && !req_dma_i) begin
            next_st.addr = FHRI_ADDR_STATUS;
            next_st.rd = 1'b1;
            next_st.fsm = FHRI_H_POLL;
          end else begin
            next_st.addr = (req_kind_i == 2'h1) ? FHRI_ADDR_FIFO :
                           (req_kind_i == 2'h2) ? FHRI_ADDR_INPUT : FHRI_ADDR_RATE;
            next_st.fsm = FHRI_H_XFER;
          end
        end
      end
      FHRI_H_POLL: next_st.fsm = FHRI_H_WAIT;
      FHRI_H_WAIT: begin
        if (bus.rdata[FHRI_RQM_BIT] && bus.rdata[FHRI_DIO_BIT] != st.is_write) begin
          next_st.addr = FHRI_ADDR_FIFO;
          next_st.fsm = FHRI_H_XFER;
        end else begin
          next_st.rd = 1'b1;
          next_st.fsm = FHRI_H_POLL;
        end
      end
      FHRI_H_XFER: begin
        next_st.wr = st.is_write;
        next_st.rd = !st.is_write;
        next_st.fsm = st.is_write ? FHRI_H_IDLE : FHRI_H_SETTLE;
      end
      // read data is registered in the device, so it lands a cycle after the strobe
      FHRI_H_SETTLE: next_st.fsm = FHRI_H_GRAB;
      FHRI_H_GRAB: next_st.fsm = FHRI_H_IDLE;
      default: next_st.fsm = FHRI_H_IDLE;
    endcase
    if (st.fsm == FHRI_H_GRAB) begin
      next_st.resp = bus.rdata;
      next_st.resp_valid = 1'b1;
    end
    if (!reset_n_i) begin
      next_st = '0;
      next_st.fsm = FHRI_H_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  always_comb begin
    bus.addr = st.addr;
    bus.rd = st.rd;
    bus.wr = st.wr;
    bus.wdata = st.wdata;
    req_ready_o = st.fsm == FHRI_H_IDLE;
    resp_data_o = st.resp;
    resp_valid_o = st.resp_valid;
  end
endmodule

/* File: verification/fhri_chk.sv */
`timescale 1ns/100ps
module fhri_chk
  import fhri_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic st_d;
  logic [7:0] last_st;
  logic [7:0] st_now;
  // the host may act on a status byte in the cycle it arrives
  assign st_now = st_d ? rdata : last_st;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_d <= 1'b0;
      last_st <= 8'h00;
    end else begin
      st_d <= rd && addr == FHRI_ADDR_STATUS;
      last_st <= st_now;
    end
  end
  sequence s_st;
    rd && addr == FHRI_ADDR_STATUS;
  endsequence
  sequence s_fifo;
    rd && addr == FHRI_ADDR_FIFO;
  endsequence
  property p_oe_st;
    s_st |=> rdata_oe == 8'hFF;
  endproperty
  a_oe_st: assert property (p_oe_st) else $error("status not driven");
  property p_oe_fifo;
    s_fifo |=> rdata_oe == 8'hFF;
  endproperty
  a_oe_fifo: assert property (p_oe_fifo) else $error("data not driven");
  property p_oe_in;
    rd && addr == FHRI_ADDR_INPUT |=> rdata_oe == 8'h80;
  endproperty
  a_oe_in: assert property (p_oe_in) else $error("input reg drive wrong");
  property p_oe_idle;
    !rd |=> rdata_oe == 8'h00;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven idle");
  property p_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_excl;
    !(rd && wr);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_rd_ok;
    s_fifo |-> st_now[7:6] == 2'h3;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("data read not allowed");
  property p_wr_ok;
    wr && addr == FHRI_ADDR_FIFO |-> st_now[7:6] == 2'h2;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("data write not allowed");
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb
  import fhri_pkg::*;
;
  logic clk_i = 0, reset_n_i = 0, pol = 1, dchg_n = 1, cfg_we = 0, out_rst = 0;
  logic busy = 0, ndma = 0, d2h = 0, xerr = 0, cw_valid = 0, cr_ready = 0;
  logic exec_st = 0, fifo_en = 0;
  logic [7:0] ptrk = 0, ctrk = 0;
  logic [1:0] opt = 0, cfg_rate = 0, rq_k = 0;
  logic [3:0] seek = 0, steps;
  logic [7:0] cw_data = 0, rq_d = 0, cr_data, rsp;
  logic rq_v = 0, rq_w = 0, cw_ready, cr_valid, dens, lowp, srst, fact, fz, rq_rdy, rsp_v;
  logic [1:0] rsel, rpin;
  fhri_rate_t drate;
  int n_errors = 0, checks_done = 0, pulses = 0;
  fhri_bus_if bus();
  fhri_device i_fhri_device(.clk_i, .reset_n_i, .bus(bus), .drive_rate_option_i(opt),
    .density_polarity_i(pol), .disk_change_n_i(dchg_n), .config_rate_i(cfg_rate),
    .config_rate_we_i(cfg_we), .output_reset_i(out_rst), .drive_seek_active_i(seek),
    .cmd_busy_i(busy), .non_dma_exec_i(ndma), .dev_to_host_i(d2h), .exec_start_i(exec_st),
    .fifo_enable_i(fifo_en), .precomp_track_i(ptrk), .core_wdata_i(cw_data),
    .core_wvalid_i(cw_valid), .core_wready_o(cw_ready), .core_rdata_o(cr_data),
    .core_rvalid_o(cr_valid), .core_rready_i(cr_ready), .transfer_error_i(xerr),
    .current_track_i(ctrk), .rate_select_bits_o(rsel), .data_rate_o(drate),
    .precomp_steps_o(steps), .density_output_o(dens), .rate_output_pin_o(rpin),
    .low_power_o(lowp), .soft_reset_o(srst), .fifo_active_o(fact), .fill_zero_o(fz));
  fhri_host i_fhri_host(.clk_i, .reset_n_i, .bus(bus), .req_valid_i(rq_v),
    .req_write_i(rq_w), .req_kind_i(rq_k), .req_data_i(rq_d), .req_dma_i(1'b0),
    .req_ready_o(rq_rdy), .resp_data_o(rsp), .resp_valid_o(rsp_v));
  fhri_chk i_fhri_chk(.clk_i, .reset_n_i, .addr(bus.addr), .rd(bus.rd), .wr(bus.wr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe));
  always #2.5 clk_i = ~clk_i;
  task cyc;
    @(posedge clk_i);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task op(input logic w, input logic [1:0] k, input logic [7:0] d);
    rq_v = 1;
    rq_w = w;
    rq_k = k;
    rq_d = d;
    for (int i = 0; i < 50 && rq_rdy !== 1'b1; i++) cyc;
    cyc;
    rq_v = 0;
    // writes leave no answer, so allow the poll and strobe to finish
    for (int i = 0; i < 50 && (w ? i < 6 : rsp_v !== 1'b1); i++) begin
      cyc;
      if (srst === 1'b1) pulses++;
    end
  endtask
  task results;
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_rates;
    logic [1:0] o_t[6] = '{0, 0, 0, 0, 1, 2};
    logic [1:0] c_t[6] = '{3, 0, 1, 2, 1, 1};
    fhri_rate_t r_t[6] = '{FHRI_RATE_CODE_1M, FHRI_RATE_CODE_500K, FHRI_RATE_CODE_300K,
      FHRI_RATE_CODE_250K, FHRI_RATE_CODE_500K, FHRI_RATE_CODE_2M};
    for (int i = 0; i < 6; i++) begin
      opt = o_t[i];
      op(1, 0, {3'h0, FHRI_PRECOMP_OFF, c_t[i]});
      chk(drate, r_t[i]);
      chk(rpin, c_t[i]);
      chk(dens, c_t[i] == 2'h3 || c_t[i] == 2'h0);
      chk(steps, 4'h0);
    end
    pol = 0;
    repeat (2) cyc;
    chk(dens, 1'b1);
    pol = 1;
    op(1, 0, 8'h01);
    chk(steps, FHRI_STEP_2M_DEF);
    opt = 0;
    op(1, 0, 8'h03);
    chk(steps, FHRI_STEP_1M_DEF);
    op(1, 0, 8'h0E);
    chk(steps, 4'h6);
    cfg_rate = 1;
    cfg_we = 1;
    cyc;
    cfg_we = 0;
    cyc;
    chk(rsel, 2'h1);
  endtask
  task t_soft;
    pulses = 0;
    op(1, 0, 8'h81);
    chk(pulses, 1);
    chk(rsel, 2'h1);
    chk(steps, FHRI_STEP_LOW_DEF);
    out_rst = 1;
    cyc;
    out_rst = 0;
    repeat (2) cyc;
    chk(dens, 1'b0);
    op(1, 0, 8'h42);
    chk(lowp, 1'b1);
    op(0, 0, 8'h00);
    repeat (2) cyc;
    chk(lowp, 1'b0);
  endtask
  task t_misc;
    logic [7:0] q[$];
    dchg_n = 0;
    repeat (5) cyc;
    op(0, 2, 8'h00);
    chk(rsp[7], 1'b1);
    seek = 4'hA;
    busy = 1;
    ndma = 1;
    repeat (2) cyc;
    op(0, 0, 8'h00);
    chk(rsp[5:0], 6'h3A);
    op(1, 1, 8'hA5);
    op(1, 1, 8'h5A);
    cr_ready = 1;
    for (int i = 0; i < 20 && q.size() < 2; i++) begin
      if (cr_valid === 1'b1) q.push_back(cr_data);
      cyc;
    end
    chk(q[0], 8'hA5);
    chk(q[1], 8'h5A);
    d2h = 1;
    cw_data = 8'hC3;
    cw_valid = 1;
    for (int i = 0; i < 20 && cw_ready !== 1'b1; i++) cyc;
    cyc;
    cw_valid = 0;
    op(0, 1, 8'h00);
    chk(rsp, 8'hC3);
    xerr = 1;
    cyc;
    xerr = 0;
    cyc;
    chk(fz, 1'b0);
    d2h = 0;
    xerr = 1;
    cyc;
    xerr = 0;
    cyc;
    chk(fz, 1'b1);
    chk(cr_data, FHRI_FILL_BYTE);
  endtask
  task t_flow;
    cr_ready = 0;
    out_rst = 1;
    cyc;
    out_rst = 0;
    fifo_en = 1;
    exec_st = 1;
    cyc;
    exec_st = 0;
    cyc;
    chk(fact, 1'b1);
    op(1, 1, 8'h3C);
    chk(cr_valid, 1'b1);
    chk(cr_data, 8'h3C);
    exec_st = 1;
    cyc;
    exec_st = 0;
    cyc;
    chk(cr_valid, 1'b0);
    out_rst = 1;
    cyc;
    out_rst = 0;
    cyc;
    chk(fact, 1'b0);
    ptrk = 8'h05;
    ctrk = 8'h04;
    cyc;
    chk(steps, 4'h0);
    ctrk = 8'h05;
    cyc;
    chk(steps, FHRI_STEP_LOW_DEF);
  endtask
  initial begin
    repeat (20) cyc;
    chk(rsel, 2'h2);
    chk(dens, 1'b1);
    chk(lowp, 1'b0);
    chk(fact, 1'b0);
    reset_n_i = 1;
    cyc;
    t_rates;
    t_soft;
    t_misc;
    t_flow;
    results;
  end
  initial begin
    #100000;
    n_errors++;
    results;
  end
endmodule
